// File: src/mcuisx_exec.v
// execution unit for the memory step, move, branch and sleep instructions
`include "mcuisx_defs.vh"

////////////////////////////////////////////////////////////////////////////////
module mcuisx_exec #(
  parameter ADDR_W = 8,
  parameter PC_W = 11,
  parameter MEM_DEPTH = 256
) (
  // clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // register command port
  input wire [3:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  // wake-up pin
  input wire wake_i,
  // status
  output reg clk_gate_o,
  output reg [PC_W-1:0] pc_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // storage and state

  localparam ST_IDLE = 3'b001;
  localparam ST_DUMMY = 3'b010;
  localparam ST_SLEEP = 3'b100;

  reg [7:0] mem_q [0:MEM_DEPTH-1];
  reg [7:0] work_q;
  reg [PC_W-1:0] pc_q;
  reg [PC_W-1:0] target_q;
  reg zero_q;
  reg sleep_flag_q;
  reg exp_flag_q;
  reg [2:0] state_q;
  reg wake_meta_q;
  reg wake_sync_q;

  wire [7:0] wdog_count;
  wire wdog_expired;
  wire wdog_clear;

  // command word: op, then address or literal, then branch target
  // commands are refused outside idle, so a busy core never loses its place
  wire cmd_go = reg_wr_i && (reg_addr_i == `MCUISX_REG_CMD) && (state_q == ST_IDLE);
  wire [3:0] op = reg_wdata_i[`MCUISX_CMD_OP_LSB+3:`MCUISX_CMD_OP_LSB];
  wire [ADDR_W-1:0] addr = reg_wdata_i[`MCUISX_CMD_ARG_LSB+ADDR_W-1:`MCUISX_CMD_ARG_LSB];
  wire [7:0] lit = reg_wdata_i[`MCUISX_CMD_ARG_LSB+7:`MCUISX_CMD_ARG_LSB];
  wire [PC_W-1:0] tgt = reg_wdata_i[`MCUISX_CMD_TGT_LSB+PC_W-1:`MCUISX_CMD_TGT_LSB];
  wire [PC_W-1:0] pc_next = pc_q + {{(PC_W-1){1'b0}}, 1'b1};
  wire [7:0] operand = mem_q[addr];
  // eight-bit sums wrap naturally
  wire [7:0] minus_one = operand - 8'h01;
  wire [7:0] plus_one = operand + 8'h01;

  ////////////////////////////////////////////////////////////////////////////////
  // wake-up synchroniser
  // the pin is asynchronous; only the second flop feeds the sequencer

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      wake_meta_q <= 1'b0;
      wake_sync_q <= 1'b0;
    end else begin
      wake_meta_q <= wake_i;
      wake_sync_q <= wake_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog

  assign wdog_clear = cmd_go && (op == `MCUISX_OP_SLEEP);

  // watchdog keeps running in sleep; only its clear on entry is part of this block
  mcuisx_wdog #(
    .PRE_W(8),
    .CNT_W(8)
  ) u_wdog (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .run_i(1'b1),
    .clear_i(wdog_clear),
    .count_o(wdog_count),
    .expired_o(wdog_expired)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // data memory, no reset so contents survive sleep

  reg mem_we;
  reg [7:0] mem_wdata;

  // only a taken command writes, so sleep and the dummy cycle leave memory alone
  always @* begin
    mem_we = 1'b0;
    mem_wdata = operand;
    if (cmd_go) begin
      case (op)
        `MCUISX_OP_MEM_MINUS: begin
          mem_we = 1'b1;
          mem_wdata = minus_one;
        end
        `MCUISX_OP_MEM_PLUS: begin
          mem_we = 1'b1;
          mem_wdata = plus_one;
        end
        `MCUISX_OP_WORK_TO_MEM: begin
          mem_we = 1'b1;
          mem_wdata = work_q;
        end
        default: begin
          mem_we = 1'b0;
        end
      endcase
    end
  end

  always @(posedge clk_sys_i) begin
    if (mem_we) begin
      mem_q[addr] <= mem_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // working register, flags, program counter, sequencer

  reg [7:0] work_d;
  reg zero_d;
  reg sleep_flag_d;
  reg exp_flag_d;
  reg [PC_W-1:0] pc_d;
  reg [PC_W-1:0] target_d;
  reg [2:0] state_d;

  always @* begin
    work_d = work_q;
    zero_d = zero_q;
    sleep_flag_d = sleep_flag_q;
    // expiry sets the flag; sleep entry clears it and the counter on the same edge
    exp_flag_d = exp_flag_q || wdog_expired;
    pc_d = pc_q;
    target_d = target_q;
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (cmd_go) begin
          // every op but the branch moves on by one word
          pc_d = pc_next;
          case (op)
            `MCUISX_OP_MEM_MINUS: begin
              zero_d = (minus_one == 8'h00);
            end
            `MCUISX_OP_MINUS_WORK: begin
              work_d = minus_one;
              zero_d = (minus_one == 8'h00);
            end
            `MCUISX_OP_MEM_PLUS: begin
              zero_d = (plus_one == 8'h00);
            end
            `MCUISX_OP_PLUS_WORK: begin
              work_d = plus_one;
              zero_d = (plus_one == 8'h00);
            end
            `MCUISX_OP_SLEEP: begin
              // work stays and pc moves on by one word, so wake resumes at the next word with work intact
              sleep_flag_d = 1'b1;
              exp_flag_d = 1'b0;
              state_d = ST_SLEEP;
            end
            `MCUISX_OP_BRANCH: begin
              pc_d = pc_q;
              target_d = tgt;
              state_d = ST_DUMMY;
            end
            `MCUISX_OP_MEM_TO_WORK: begin
              work_d = operand;
            end
            `MCUISX_OP_IMM_TO_WORK: begin
              work_d = lit;
            end
            `MCUISX_OP_WORK_TO_MEM: begin
              work_d = work_q;
            end
            default: begin
              work_d = work_q;
            end
          endcase
        end else if (reg_wr_i && (reg_addr_i == `MCUISX_REG_WORK)) begin
          work_d = reg_wdata_i[7:0];
        end else if (reg_wr_i && (reg_addr_i == `MCUISX_REG_STATUS)) begin
          // software clears sticky flags by writing one; a live expiry wins
          if (reg_wdata_i[`MCUISX_ST_SLEEP]) begin
            sleep_flag_d = 1'b0;
          end
          if (reg_wdata_i[`MCUISX_ST_WDOG_EXP] && !wdog_expired) begin
            exp_flag_d = 1'b0;
          end
        end
      end
      ST_DUMMY: begin
        // the dummy cycle executes nothing
        pc_d = target_q;
        state_d = ST_IDLE;
      end
      ST_SLEEP: begin
        if (wake_sync_q) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      work_q <= `MCUISX_WORK_RST;
      zero_q <= 1'b0;
      sleep_flag_q <= 1'b0;
      exp_flag_q <= 1'b0;
      pc_q <= `MCUISX_PC_RST;
      target_q <= `MCUISX_PC_RST;
      state_q <= ST_IDLE;
    end else begin
      work_q <= work_d;
      zero_q <= zero_d;
      sleep_flag_q <= sleep_flag_d;
      exp_flag_q <= exp_flag_d;
      pc_q <= pc_d;
      target_q <= target_d;
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs and read port

  reg [31:0] status_word;
  reg [31:0] rdata_d;

  // status built bit by bit from the field positions that software uses
  always @* begin
    status_word = 32'h00000000;
    status_word[`MCUISX_ST_ZERO] = zero_q;
    status_word[`MCUISX_ST_SLEEP] = sleep_flag_q;
    status_word[`MCUISX_ST_WDOG_EXP] = exp_flag_q;
    status_word[`MCUISX_ST_BUSY] = (state_q != ST_IDLE);
  end

  // read data stand for one cycle only, zero otherwise
  always @* begin
    rdata_d = 32'h00000000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `MCUISX_REG_WORK: begin
          rdata_d = {24'h000000, work_q};
        end
        `MCUISX_REG_STATUS: begin
          rdata_d = status_word;
        end
        `MCUISX_REG_PC: begin
          rdata_d = {{(32-PC_W){1'b0}}, pc_q};
        end
        `MCUISX_REG_WDOG: begin
          rdata_d = {24'h000000, wdog_count};
        end
        default: begin
          rdata_d = 32'h00000000;
        end
      endcase
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      clk_gate_o <= 1'b0;
      pc_o <= `MCUISX_PC_RST;
      reg_rdata_o <= 32'h00000000;
    end else begin
      // gate the core clock while asleep; the block keeps clocking to see wake
      clk_gate_o <= (state_q == ST_SLEEP) && !wake_sync_q;
      pc_o <= pc_q;
      reg_rdata_o <= rdata_d;
    end
  end

endmodule // mcuisx_exec

// File: src/mcuisx_defs.vh
// constants for the instruction subset execution block
`ifndef MCUISX_DEFS_VH
`define MCUISX_DEFS_VH

// operation codes presented in the low four bits of the command word
`define MCUISX_OP_NOP 4'h0
`define MCUISX_OP_MEM_MINUS 4'h1
`define MCUISX_OP_MINUS_WORK 4'h2
`define MCUISX_OP_MEM_PLUS 4'h3
`define MCUISX_OP_PLUS_WORK 4'h4
`define MCUISX_OP_SLEEP 4'h5
`define MCUISX_OP_BRANCH 4'h6
`define MCUISX_OP_MEM_TO_WORK 4'h7
`define MCUISX_OP_IMM_TO_WORK 4'h8
`define MCUISX_OP_WORK_TO_MEM 4'h9

// command word field positions
`define MCUISX_CMD_OP_LSB 0
`define MCUISX_CMD_ARG_LSB 8
`define MCUISX_CMD_TGT_LSB 16

// register command port offsets
`define MCUISX_REG_CMD 4'h0
`define MCUISX_REG_WORK 4'h1
`define MCUISX_REG_STATUS 4'h2
`define MCUISX_REG_PC 4'h3
`define MCUISX_REG_WDOG 4'h4

// status register field positions
`define MCUISX_ST_ZERO 0
`define MCUISX_ST_SLEEP 1
`define MCUISX_ST_WDOG_EXP 2
`define MCUISX_ST_BUSY 3

// reset values
`define MCUISX_WORK_RST 8'h00
`define MCUISX_PC_RST 11'h000

`endif

// File: src/mcuisx_wdog.v
// watchdog counter with prescaler, cleared on request
module mcuisx_wdog #(
  parameter PRE_W = 8,
  parameter CNT_W = 8
) (
  // clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // control
  input wire run_i,
  input wire clear_i,
  // state
  output wire [CNT_W-1:0] count_o,
  output wire expired_o
);

  reg [PRE_W-1:0] pre_q;
  reg [CNT_W-1:0] cnt_q;
  reg exp_q;

  always @(posedge clk_sys_i) begin
    if (reset_i || clear_i) begin
      pre_q <= {PRE_W{1'b0}};
      cnt_q <= {CNT_W{1'b0}};
      exp_q <= 1'b0;
    end else if (run_i) begin
      pre_q <= pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
      if (&pre_q) begin
        cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        if (&cnt_q) begin
          exp_q <= 1'b1;
        end
      end
    end
  end

  assign count_o = cnt_q;
  assign expired_o = exp_q;

endmodule // mcuisx_wdog

// File: test/mcuisx_exec_monitor.sv
// port checker for the execution block
module mcuisx_exec_monitor #(
  parameter PC_W = 11
) (
  // clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // register port
  input wire [3:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [31:0] reg_rdata_o,
  // wake and status
  input wire wake_i,
  input wire clk_gate_o,
  input wire [PC_W-1:0] pc_o
);
  // a command written while the clock is not gated; the core still refuses those written during the dummy cycle
  wire cmd_w = reg_wr_i && reg_addr_i == 4'h0 && !clk_gate_o;
  wire jmp_w = cmd_w && reg_wdata_i[3:0] == 4'h6;
  wire nap_w = cmd_w && reg_wdata_i[3:0] == 4'h5;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data not zero outside answer");
  a_rdata_unmap: assert property ($past(reg_rd_i && reg_addr_i > 4'h4) |-> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_branch_pc: assert property (jmp_w |-> ##3 pc_o == $past(reg_wdata_i[26:16], 3))
    else $error("branch target not loaded");
  a_branch_dummy: assert property (jmp_w |-> ##2 $stable(pc_o))
    else $error("branch without dummy cycle");
  a_step_pc: assert property (cmd_w && reg_wdata_i[3:0] != 4'h6 && !$past(jmp_w)
    |-> ##2 pc_o == $past(pc_o) + 1'b1)
    else $error("pc not advanced by one");
  a_nap_gate: assert property (nap_w |-> ##2 clk_gate_o)
    else $error("sleep did not gate clock");
  a_gate_cause: assert property ($rose(clk_gate_o) |-> $past(nap_w, 2))
    else $error("clock gated without sleep");
  a_gate_hold: assert property (clk_gate_o && !wake_i && !$past(wake_i) && !$past(wake_i, 2)
    && !$past(wake_i, 3) |=> clk_gate_o)
    else $error("woke without wake-up");
  a_wake_drop: assert property (clk_gate_o && $rose(wake_i) |-> ##[1:6] !clk_gate_o)
    else $error("wake-up not seen");
  a_sleep_pc: assert property (clk_gate_o && $past(clk_gate_o) |-> $stable(pc_o))
    else $error("pc moved while asleep");
endmodule // mcuisx_exec_monitor

bind mcuisx_exec mcuisx_exec_monitor #(.PC_W(PC_W)) mcuisx_exec_monitor_inst (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .wake_i(wake_i), .clk_gate_o(clk_gate_o), .pc_o(pc_o));

// File: test/mcu_instruction_subset_exec_bench.sv
// self-checking bench for the execution block
module mcu_instruction_subset_exec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic wake_i = 1'b0;
  wire [31:0] reg_rdata_o;
  wire clk_gate_o;
  wire [10:0] pc_o;
  logic [31:0] rv;
  logic g;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  mcuisx_exec mcuisx_exec_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .wake_i(wake_i),
    .clk_gate_o(clk_gate_o), .pc_o(pc_o));
  always #2.5 clk_sys_i = ~clk_sys_i;
  ////////////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // the whole run is under a thousand cycles, far below watchdog expiry
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      finish_test;
    end
  end
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one idle cycle after each access keeps every strobe one cycle long
  task wr(input logic [3:0] a, input logic [31:0] d);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task rd(input logic [3:0] a);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 rv = reg_rdata_o;
    g = clk_gate_o;
    @(posedge clk_sys_i);
  endtask
  task cmd(input logic [3:0] op, input logic [7:0] b, input logic [10:0] t);
    wr(4'h0, {5'h00, t, b, 4'h0, op});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_moves;
    cmd(4'h8, 8'hA5, 11'h000);
    cmd(4'h9, 8'h10, 11'h000);
    cmd(4'h8, 8'h00, 11'h000);
    rd(4'h2);
    chk("status", 32'h0, {28'h0, rv[3:0]});
    cmd(4'h7, 8'h10, 11'h000);
    rd(4'h1);
    chk("work", 32'hA5, rv);
    rd(4'h2);
    chk("status", 32'h0, {28'h0, rv[3:0]});
    rd(4'h9);
    chk("unmapped", 32'h0, rv);
  endtask
  task t_step(input logic [3:0] op, input logic [7:0] a, v, r, input logic to_mem);
    cmd(4'h8, v, 11'h000);
    cmd(4'h9, a, 11'h000);
    cmd(op, a, 11'h000);
    rd(4'h2);
    chk("status", {31'h0, r == 8'h00}, {28'h0, rv[3:0]});
    rd(4'h1);
    chk("work", {24'h0, to_mem ? v : r}, rv);
    cmd(4'h7, a, 11'h000);
    rd(4'h1);
    chk("memory", {24'h0, to_mem ? r : v}, rv);
  endtask
  task t_branch;
    cmd(4'h8, 8'h5E, 11'h000);
    reg_wr_i <= 1'b1;
    reg_addr_i <= 4'h0;
    reg_wdata_i <= {5'h00, 11'h5A3, 16'h0006};
    @(posedge clk_sys_i);
    reg_wdata_i <= 32'h00003C08;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    rd(4'h3);
    chk("pc", 32'h5A3, rv);
    chk("pc out", 32'h5A3, {21'h0, pc_o});
    rd(4'h1);
    chk("work", 32'h5E, rv);
    rd(4'h2);
    chk("status", 32'h1, {28'h0, rv[3:0]});
  endtask
  task t_sleep;
    // let the watchdog pass its prescaler so the clear on entry is visible
    repeat (600) @(posedge clk_sys_i);
    rd(4'h4);
    chk("watchdog run", 32'h1, {31'h0, rv != 32'h0});
    cmd(4'h5, 8'h00, 11'h000);
    rd(4'h2);
    chk("status", 32'hB, {28'h0, rv[3:0]});
    chk("gate", 32'h1, {31'h0, g});
    rd(4'h4);
    chk("watchdog", 32'h0, rv);
    cmd(4'h8, 8'h11, 11'h000);
    rd(4'h1);
    chk("work", 32'h5E, rv);
    wake_i <= 1'b1;
    for (int i = 0; i < 12 && g; i++) begin
      @(posedge clk_sys_i);
      #1 g = clk_gate_o;
    end
    @(posedge clk_sys_i);
    wake_i <= 1'b0;
    chk("gate", 32'h0, {31'h0, g});
    repeat (2) @(posedge clk_sys_i);
    cmd(4'h7, 8'h10, 11'h000);
    rd(4'h1);
    chk("memory", 32'hA5, rv);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    t_moves;
    t_step(4'h1, 8'h21, 8'h01, 8'h00, 1'b1);
    t_step(4'h1, 8'h22, 8'h00, 8'hFF, 1'b1);
    t_step(4'h2, 8'h23, 8'h01, 8'h00, 1'b0);
    t_step(4'h3, 8'h24, 8'hFF, 8'h00, 1'b1);
    t_step(4'h4, 8'h25, 8'h7F, 8'h80, 1'b0);
    t_step(4'h4, 8'h26, 8'hFF, 8'h00, 1'b0);
    t_branch;
    t_sleep;
    finish_test;
  end
endmodule // mcu_instruction_subset_exec_bench
